//--- src/tlm_monitor.sv
// temperature limit monitor: threshold, hysteresis, delays, telegrams
// assumes synchronous inputs on CLK_I and a classic Wishbone master
//
// Functional notes
// - upper modes: above threshold gives one state, below thr-hyst other.
// - lower modes: below threshold gives one state, above thr+hyst other.
// - twelve modes; some give no telegram for one crossing.
// - external 16-bit selection takes threshold from a two-byte object.
// - external 8-bit selection takes threshold from a one-byte object.
// - teaching: store object write copies current sample into threshold.
// - configuration download overwrites any external threshold.
// - after download, external threshold used only after new value.
// - switch-on delay from table elapses before state 1 accepted.
// - during switch-on delay cyclic telegrams still carry 0.
// - switch-off delay from same table elapses before state 0.
// - during switch-off delay cyclic telegrams still carry 1.
// - no cyclic telegram while a no-telegram condition holds.
// - send-on-change sends the state on every change.
// - without send-on-change a state change sends nothing.
// - cyclic setting of one or more sends state periodically.
// - cyclic period is setting (0 to 120) times ten seconds.
// - cyclic setting zero disables periodic sending.
// - no send-on-change and cyclic zero means never sending.
// - configured threshold limited to -15 to +50 degrees Celsius.
// - hysteresis chosen from none, 1-5, 10, 15, 20 kelvin.
`timescale 1ns/1ps
`default_nettype none
`include "tlm_regs.svh"

module tlm_monitor
   import tlm_pkg::*;
#(
   parameter int unsigned SEC_CYCLES = `TLM_SECOND_NS / `TLM_CLK_PERIOD_NS
)
(
   // clock, reset, enable
   input wire logic CLK_I,
   input wire logic RST_I,
   input wire logic CE_I,
   // wishbone slave
   input wire logic CYC_I,
   input wire logic STB_I,
   input wire logic WE_I,
   input wire logic [4:0] ADR_I,
   input wire logic [3:0] SEL_I,
   input wire logic [31:0] DAT_I,
   output logic [31:0] DAT_O,
   output logic ACK_O,
   // measured temperature, 0.1 degC signed
   input wire logic [15:0] SAMPLE_I,
   input wire logic SAMPLE_VALID_I,
   // external value objects
   input wire logic [15:0] EXT16_I,
   input wire logic EXT16_WR_I,
   input wire logic [7:0] EXT8_I,
   input wire logic EXT8_WR_I,
   input wire logic TEACH_WR_I,
   // limit state telegrams
   output logic TX_O,
   output logic TX_STATE_O,
   output logic LIMIT_O
);

   localparam logic [31:0] SEC_LAST = 32'(SEC_CYCLES - 1);

   tlm_state_t r;
   tlm_state_t n;

   logic wb_req;
   logic wr;
   logic dl;
   logic ext_take;
   logic keep;
   logic tgt;
   logic cyc_fire;
   logic [11:0] on_secs;
   logic [11:0] off_secs;
   logic signed [16:0] s17;
   logic signed [16:0] thr17;
   logic signed [16:0] hyst17;
   tlm_act_t act;

   // delay choice index to seconds
   function automatic logic [11:0] dly_secs(input logic [3:0] idx);
      unique case (idx)
         4'h0: dly_secs = 12'h000;
         4'h1: dly_secs = 12'h001;
         4'h2: dly_secs = 12'h003;
         4'h3: dly_secs = 12'h005;
         4'h4: dly_secs = 12'h00A;
         4'h5: dly_secs = 12'h00F;
         4'h6: dly_secs = 12'h01E;
         4'h7: dly_secs = 12'h03C;
         4'h8: dly_secs = 12'h0B4;
         4'h9: dly_secs = 12'h12C;
         4'hA: dly_secs = 12'h258;
         4'hB: dly_secs = 12'h384;
         4'hC: dly_secs = 12'h708;
         default: dly_secs = 12'hE10;
      endcase
   endfunction : dly_secs

   // hysteresis index to tenths of a kelvin
   function automatic logic [16:0] hyst_tenths(input logic [3:0] idx);
      unique case (idx)
         4'h0: hyst_tenths = 17'h00000;
         4'h1: hyst_tenths = 17'h0000A;
         4'h2: hyst_tenths = 17'h00014;
         4'h3: hyst_tenths = 17'h0001E;
         4'h4: hyst_tenths = 17'h00028;
         4'h5: hyst_tenths = 17'h00032;
         4'h6: hyst_tenths = 17'h00064;
         4'h7: hyst_tenths = 17'h00096;
         default: hyst_tenths = 17'h000C8;
      endcase
   endfunction : hyst_tenths

   // whole degrees to tenths
   function automatic logic [15:0] scale10(input logic [7:0] deg);
      scale10 = 16'($signed(deg) * 16'sd10);
   endfunction : scale10

   // modes 0,1,4,5,8,9 watch the upper threshold
   function automatic logic is_upper(input logic [3:0] mode);
      is_upper = (mode == 4'h0) || (mode == 4'h1) || (mode == 4'h4) ||
         (mode == 4'h5) || (mode == 4'h8) || (mode == 4'h9);
   endfunction : is_upper

   // action for crossing into (prim) or back out of the condition
   function automatic tlm_act_t mode_act(input logic [3:0] mode,
                                         input logic prim);
      unique case (mode)
         4'h0, 4'h2: mode_act = prim ? ACT_ON : ACT_OFF;
         4'h1, 4'h3: mode_act = prim ? ACT_OFF : ACT_ON;
         4'h4, 4'h6: mode_act = prim ? ACT_ON : ACT_NONE;
         4'h5, 4'h7: mode_act = prim ? ACT_OFF : ACT_NONE;
         4'h8, 4'hA: mode_act = prim ? ACT_NONE : ACT_OFF;
         default: mode_act = prim ? ACT_NONE : ACT_ON;
      endcase
   endfunction : mode_act

   // clamp configured threshold byte
   function automatic logic [7:0] clamp_thr(input logic [7:0] v);
      if ($signed(v) < 8'(`TLM_THR_MIN_C))
      begin
         clamp_thr = 8'(`TLM_THR_MIN_C);
      end
      else if ($signed(v) > 8'(`TLM_THR_MAX_C))
      begin
         clamp_thr = 8'(`TLM_THR_MAX_C);
      end
      else
      begin
         clamp_thr = v;
      end
   endfunction : clamp_thr

   assign s17 = 17'($signed(SAMPLE_I));
   assign thr17 = 17'($signed(r.thr));
   assign hyst17 = hyst_tenths(r.hyst_idx);
   assign on_secs = dly_secs(r.on_idx);
   assign off_secs = dly_secs(r.off_idx);
   assign act = mode_act(r.mode, r.cond);
   assign keep = (act == ACT_NONE);
   assign tgt = (act == ACT_ON);
   assign cyc_fire = (r.cyc_set != 7'h00) && (r.cyc_sub == SEC_LAST) &&
      (r.cyc_sec == 11'(r.cyc_set * 11'd`TLM_CYC_UNIT_S) - 11'd1);
   assign wb_req = CYC_I && STB_I && !r.ack;
   assign wr = wb_req && WE_I;
   assign dl = wr && (ADR_I == `TLM_OFS_THR);
   assign ext_take = ((r.src == SRC_EXT16) && EXT16_WR_I) ||
      ((r.src == SRC_EXT8) && EXT8_WR_I) ||
      ((r.src == SRC_TEACH) && TEACH_WR_I);

   always_comb
   begin
      n = r;
      n.tx = 1'b0;
      n.ack = wb_req;
      n.rdat = 32'h0000_0000;
      // register reads
      if (wb_req && !WE_I)
      begin
         unique case (ADR_I)
            `TLM_OFS_CTRL: n.rdat = {8'h00, r.off_idx, r.on_idx, 1'b0,
               r.cyc_set, 1'b0, r.soc, r.src, r.mode};
            `TLM_OFS_THR: n.rdat = {20'h00000, r.hyst_idx, r.cfg_thr};
            `TLM_OFS_STATUS: n.rdat = {r.thr, 11'h000, r.ext_valid, r.dly,
               r.cond, r.lim};
            `TLM_OFS_SAMPLE: n.rdat = {16'h0000, r.sample};
            default: n.rdat = 32'h0000_0000;
         endcase
      end
      // control writes, out-of-range mode ignored, other out-of-range values clamped
      if (wr && (ADR_I == `TLM_OFS_CTRL))
      begin
         if (SEL_I[0])
         begin
            if (DAT_I[`TLM_CTRL_MODE_LSB +: 4] <= `TLM_MODE_MAX)
            begin
               n.mode = DAT_I[`TLM_CTRL_MODE_LSB +: 4];
            end
            n.src = tlm_src_t'(DAT_I[`TLM_CTRL_SRC_LSB +: 2]);
            n.soc = DAT_I[`TLM_CTRL_SOC_BIT];
         end
         if (SEL_I[1])
         begin
            n.cyc_set = (DAT_I[`TLM_CTRL_CYC_LSB +: 7] > `TLM_CYC_MAX) ?
               `TLM_CYC_MAX : DAT_I[`TLM_CTRL_CYC_LSB +: 7];
         end
         if (SEL_I[2])
         begin
            n.on_idx = (DAT_I[`TLM_CTRL_ON_LSB +: 4] > `TLM_DLY_IDX_MAX) ?
               `TLM_DLY_IDX_MAX : DAT_I[`TLM_CTRL_ON_LSB +: 4];
            n.off_idx = (DAT_I[`TLM_CTRL_OFF_LSB +: 4] > `TLM_DLY_IDX_MAX) ?
               `TLM_DLY_IDX_MAX : DAT_I[`TLM_CTRL_OFF_LSB +: 4];
         end
      end
      // threshold sources
      if ((r.src == SRC_EXT16) && EXT16_WR_I)
      begin
         n.thr = EXT16_I;
         n.ext_valid = 1'b1;
      end
      else if ((r.src == SRC_EXT8) && EXT8_WR_I)
      begin
         n.thr = scale10(EXT8_I);
         n.ext_valid = 1'b1;
      end
      else if ((r.src == SRC_TEACH) && TEACH_WR_I)
      begin
         n.thr = r.sample;
         n.ext_valid = 1'b1;
      end
      // download wins over any external value
      if (dl)
      begin
         if (SEL_I[0])
         begin
            n.cfg_thr = clamp_thr(DAT_I[`TLM_THR_CFG_LSB +: 8]);
         end
         if (SEL_I[1])
         begin
            n.hyst_idx = (DAT_I[`TLM_THR_HYST_LSB +: 4] > `TLM_HYST_IDX_MAX) ?
               `TLM_HYST_IDX_MAX : DAT_I[`TLM_THR_HYST_LSB +: 4];
         end
         n.thr = scale10(n.cfg_thr);
         n.ext_valid = 1'b0;
      end
      // comparison with hysteresis band
      if (SAMPLE_VALID_I)
      begin
         n.sample = SAMPLE_I;
         if (is_upper(r.mode))
         begin
            if (s17 > thr17)
            begin
               n.cond = 1'b1;
            end
            else if (s17 < thr17 - hyst17)
            begin
               n.cond = 1'b0;
            end
         end
         else
         begin
            if (s17 < thr17)
            begin
               n.cond = 1'b1;
            end
            else if (s17 > thr17 + hyst17)
            begin
               n.cond = 1'b0;
            end
         end
      end
      // switch delays
      unique case (r.dly)
         DLY_IDLE:
         begin
            n.dly_sub = 32'h0000_0000;
            n.dly_sec = 12'h000;
            if (!keep && (tgt != r.lim))
            begin
               if (tgt)
               begin
                  if (on_secs == 12'h000)
                  begin
                     n.lim = 1'b1;
                  end
                  else
                  begin
                     n.dly = DLY_WAIT_ON;
                  end
               end
               else if (off_secs == 12'h000)
               begin
                  n.lim = 1'b0;
               end
               else
               begin
                  n.dly = DLY_WAIT_OFF;
               end
            end
         end
         DLY_WAIT_ON, DLY_WAIT_OFF:
         begin
            if (keep || (tgt != (r.dly == DLY_WAIT_ON)))
            begin
               n.dly = DLY_IDLE;
            end
            else if (r.dly_sec >=
                     ((r.dly == DLY_WAIT_ON) ? on_secs : off_secs))
            begin
               n.lim = tgt;
               n.dly = DLY_IDLE;
            end
            else if (r.dly_sub == SEC_LAST)
            begin
               n.dly_sub = 32'h0000_0000;
               n.dly_sec = r.dly_sec + 12'h001;
            end
            else
            begin
               n.dly_sub = r.dly_sub + 32'h0000_0001;
            end
         end
         default:
         begin
            n.dly = DLY_IDLE;
         end
      endcase
      // cyclic timer
      if (r.cyc_set == 7'h00)
      begin
         n.cyc_sub = 32'h0000_0000;
         n.cyc_sec = 11'h000;
      end
      else if (r.cyc_sub == SEC_LAST)
      begin
         n.cyc_sub = 32'h0000_0000;
         n.cyc_sec = cyc_fire ? 11'h000 : r.cyc_sec + 11'h001;
      end
      else
      begin
         n.cyc_sub = r.cyc_sub + 32'h0000_0001;
      end
      // cyclic telegram carries accepted state
      if (cyc_fire && !keep)
      begin
         n.tx = 1'b1;
         n.tx_val = r.lim;
      end
      // change telegram only when enabled
      if ((n.lim != r.lim) && r.soc)
      begin
         n.tx = 1'b1;
         n.tx_val = n.lim;
      end
   end

   always_ff @(posedge CLK_I)
   begin
      if (RST_I)
      begin
         r <= '0;
         r.mode <= `TLM_MODE_RST;
         r.cyc_set <= `TLM_CYC_RST;
         r.cfg_thr <= `TLM_CFG_THR_RST;
         r.hyst_idx <= `TLM_HYST_RST;
         r.thr <= scale10(`TLM_CFG_THR_RST);
      end
      else if (CE_I)
      begin
         r <= n;
      end
   end

   assign DAT_O = r.rdat;
   assign ACK_O = r.ack;
   assign TX_O = r.tx;
   assign TX_STATE_O = r.tx_val;
   assign LIMIT_O = r.lim;

   default clocking cb @(posedge CLK_I);
   endclocking
   default disable iff (RST_I);

   sequence teach_req;
      CE_I && (r.src == SRC_TEACH) && TEACH_WR_I && !dl;
   endsequence

   sequence thr_is_old_sample(logic [15:0] s);
      ##1 (r.thr == $past(s)) && r.ext_valid;
   endsequence

   upper_trip_a: assert property (CE_I && SAMPLE_VALID_I && is_upper(r.mode)
      && (s17 > thr17) |=> r.cond)
      else $error("upper crossing not taken");
   upper_clear_a: assert property (CE_I && SAMPLE_VALID_I && is_upper(r.mode)
      && (s17 < thr17 - hyst17) |=> !r.cond)
      else $error("upper release not taken");
   lower_trip_a: assert property (CE_I && SAMPLE_VALID_I && !is_upper(r.mode)
      && (s17 < thr17) |=> r.cond)
      else $error("lower crossing not taken");
   band_hold_a: assert property (!(CE_I && SAMPLE_VALID_I)
      |=> $stable(r.cond))
      else $error("condition moved without a sample");
   teach_copy_a: assert property (teach_req |-> thr_is_old_sample(r.sample))
      else $error("teach did not copy sample");
   download_a: assert property (CE_I && dl
      |=> !r.ext_valid && (r.thr == scale10(r.cfg_thr)))
      else $error("download did not restore threshold");
   on_delay_a: assert property ($rose(r.lim)
      |-> ($past(r.dly) == DLY_WAIT_ON) || ($past(on_secs) == 12'h000))
      else $error("state 1 accepted without delay");
   wait_on_old_a: assert property (CE_I && (r.dly == DLY_WAIT_ON) && cyc_fire
      && !keep && tgt && (r.dly_sec < on_secs) |=> TX_O && !TX_STATE_O)
      else $error("cyclic value not old 0");
   wait_off_old_a: assert property (CE_I && (r.dly == DLY_WAIT_OFF)
      && cyc_fire && !keep && !tgt && (r.dly_sec < off_secs)
      |=> TX_O && TX_STATE_O)
      else $error("cyclic value not old 1");
   silent_a: assert property (CE_I && !r.soc && (r.cyc_set == 7'h00)
      |=> !TX_O)
      else $error("telegram while sending disabled");
   change_tx_a: assert property (CE_I && r.soc && (n.lim != r.lim)
      |=> TX_O && (TX_STATE_O == LIMIT_O))
      else $error("change not sent");

endmodule : tlm_monitor

`default_nettype wire

//--- src/tlm_regs.svh
// register offsets, field positions, reset values and timing counts
// assumes a 32-bit classic Wishbone slave with byte addresses
`ifndef TLM_REGS_SVH
`define TLM_REGS_SVH

// register byte offsets
`define TLM_OFS_CTRL 5'h00
`define TLM_OFS_THR 5'h04
`define TLM_OFS_STATUS 5'h08
`define TLM_OFS_SAMPLE 5'h0C

// control fields
`define TLM_CTRL_MODE_LSB 0
`define TLM_CTRL_SRC_LSB 4
`define TLM_CTRL_SOC_BIT 6
`define TLM_CTRL_CYC_LSB 8
`define TLM_CTRL_ON_LSB 16
`define TLM_CTRL_OFF_LSB 20

// threshold fields
`define TLM_THR_CFG_LSB 0
`define TLM_THR_HYST_LSB 8

// status fields
`define TLM_STAT_LIM_BIT 0
`define TLM_STAT_COND_BIT 1
`define TLM_STAT_DLY_LSB 2
`define TLM_STAT_EXT_BIT 4
`define TLM_STAT_THR_LSB 16

// reset values
`define TLM_MODE_RST 4'h0
`define TLM_CYC_RST 7'h00
`define TLM_CFG_THR_RST 8'h00
`define TLM_HYST_RST 4'h0

// value ranges
`define TLM_MODE_MAX 4'hB
`define TLM_CYC_MAX 7'h78
`define TLM_DLY_IDX_MAX 4'hD
`define TLM_HYST_IDX_MAX 4'h8
`define TLM_THR_MIN_C (-15)
`define TLM_THR_MAX_C 50

// timing
`define TLM_CLK_PERIOD_NS 20
`define TLM_SECOND_NS 1000000000
`define TLM_CYC_UNIT_S 10

`endif

//--- src/tlm_pkg.sv
// types shared by the temperature limit monitor
// assumes nothing beyond the SystemVerilog language
package tlm_pkg;

   typedef enum logic [1:0] {ACT_NONE, ACT_ON, ACT_OFF} tlm_act_t;

   typedef enum logic [1:0] {
      SRC_CFG, SRC_EXT16, SRC_EXT8, SRC_TEACH
   } tlm_src_t;

   typedef enum logic [1:0] {DLY_IDLE, DLY_WAIT_ON, DLY_WAIT_OFF} tlm_dly_t;

   typedef struct packed {
      logic ack;
      logic [31:0] rdat;
      logic [3:0] mode;
      tlm_src_t src;
      logic soc;
      logic [6:0] cyc_set;
      logic [3:0] on_idx;
      logic [3:0] off_idx;
      logic [7:0] cfg_thr;
      logic [3:0] hyst_idx;
      logic [15:0] thr;
      logic ext_valid;
      logic [15:0] sample;
      logic cond;
      logic lim;
      tlm_dly_t dly;
      logic [31:0] dly_sub;
      logic [11:0] dly_sec;
      logic [31:0] cyc_sub;
      logic [10:0] cyc_sec;
      logic tx;
      logic tx_val;
   } tlm_state_t;

endpackage : tlm_pkg

//--- bench/tlm_bus_partner.sv
// far-side bus model: value object writers and telegram counter
// assumes the bench calls its tasks and shares the monitor clock
`timescale 1ns/1ps
`default_nettype none

module tlm_bus_partner
(
   // clock and telegrams
   input wire logic clk_i,
   input wire logic tx_i,
   output logic [15:0] tel_cnt_o = 16'h0000,
   // value objects
   output logic [15:0] ext16_o = 16'h0000,
   output logic ext16_wr_o = 1'b0,
   output logic [7:0] ext8_o = 8'h00,
   output logic ext8_wr_o = 1'b0,
   output logic teach_wr_o = 1'b0
);

   always @(posedge clk_i)
      if (tx_i === 1'b1)
         tel_cnt_o <= tel_cnt_o + 16'h0001;

   // object writes; data lines inverted once released
   task automatic send16(input logic [15:0] v);
      @(posedge clk_i);
      ext16_o <= v;
      ext16_wr_o <= 1'b1;
      @(posedge clk_i);
      ext16_o <= ~v;
      ext16_wr_o <= 1'b0;
   endtask : send16

   task automatic send8(input logic [7:0] v);
      @(posedge clk_i);
      ext8_o <= v;
      ext8_wr_o <= 1'b1;
      @(posedge clk_i);
      ext8_o <= ~v;
      ext8_wr_o <= 1'b0;
   endtask : send8

   task automatic teach();
      @(posedge clk_i);
      teach_wr_o <= 1'b1;
      @(posedge clk_i);
      teach_wr_o <= 1'b0;
   endtask : teach
endmodule : tlm_bus_partner
`default_nettype wire

//--- bench/tlm_monitor_bench.sv
// self-checking bench of the temperature limit monitor
// assumes design files and the far-side model are compiled first
`timescale 1ns/1ps
`default_nettype none
`include "tlm_regs.svh"

module tlm_monitor_bench;
   localparam int SEC = 4;
   localparam int MAX_CYC = 5000;
   localparam logic [15:0] HI = 16'h0032;
   localparam logic [15:0] LO = 16'hFFCE;
   logic clk = 1'b0;
   logic rst = 1'b1;
   logic ce = 1'b1;
   logic cyc = 1'b0;
   logic stb = 1'b0;
   logic we = 1'b0;
   logic [4:0] adr = 5'h00;
   logic [3:0] sel = 4'hF;
   logic [31:0] dat_w = 32'h0;
   logic [31:0] dat_r;
   logic ack;
   logic [15:0] sample = 16'h0000;
   logic sample_vld = 1'b0;
   logic [15:0] ext16;
   logic ext16_wr;
   logic [7:0] ext8;
   logic ext8_wr;
   logic teach_wr;
   logic tx;
   logic tx_state;
   logic limit;
   logic [15:0] tel_cnt;
   int err_count = 0;
   int check_count = 0;
   int cycles = 0;
   int seed = 1493;
   int tel_total = 0;
   int cur_mode = 0;
   logic soc_on = 1'b0;
   logic lim_exp = 1'b0;
   logic lim_ok = 1'b1;
   logic [15:0] r;
   logic [10:0] pat = 11'b000000_11100;
   logic tel_q[$];
   logic [31:0] val_q[$];
   logic [31:0] msk_q[$];
   // per mode: [3:2] high side, [1:0] low side; 1 on, 2 off
   logic [3:0] act_tab[12] = '{4'h6, 4'h9, 4'h9, 4'h6, 4'h4, 4'h8,
                               4'h1, 4'h2, 4'h2, 4'h1, 4'h8, 4'h4};

   always #10 clk = ~clk;

   tlm_monitor #(.SEC_CYCLES(SEC)) dut (.CLK_I(clk), .RST_I(rst),
      .CE_I(ce), .CYC_I(cyc), .STB_I(stb), .WE_I(we), .ADR_I(adr),
      .SEL_I(sel), .DAT_I(dat_w), .DAT_O(dat_r), .ACK_O(ack),
      .SAMPLE_I(sample), .SAMPLE_VALID_I(sample_vld), .EXT16_I(ext16),
      .EXT16_WR_I(ext16_wr), .EXT8_I(ext8), .EXT8_WR_I(ext8_wr),
      .TEACH_WR_I(teach_wr), .TX_O(tx), .TX_STATE_O(tx_state),
      .LIMIT_O(limit));

   tlm_bus_partner far (.clk_i(clk), .tx_i(tx), .tel_cnt_o(tel_cnt),
      .ext16_o(ext16), .ext16_wr_o(ext16_wr), .ext8_o(ext8),
      .ext8_wr_o(ext8_wr), .teach_wr_o(teach_wr));

   task automatic check(input logic [31:0] seen, input logic [31:0] exp);
      check_count++;
      if (seen !== exp)
      begin
         err_count++;
         $display("wrong value at %0t: seen %h expected %h", $time, seen,
            exp);
      end
   endtask : check

   task automatic stop_test();
      $display("checks %0d errors %0d", check_count, err_count);
      if (err_count == 0 && check_count > 0)
         $display("TEST PASSED");
      else
         $display("TEST FAILED");
      $finish;
   endtask : stop_test

   always @(posedge clk)
   begin
      cycles <= cycles + 1;
      if (cycles == MAX_CYC)
      begin
         err_count++;
         stop_test();
      end
   end

   // result watcher: telegrams and read data against the notes
   always @(posedge clk)
   begin
      if (tx === 1'b1 && tel_q.size() == 0)
         check({31'h0, tx}, 32'h0);
      else if (tx === 1'b1)
         check({31'h0, tx_state}, {31'h0, tel_q.pop_front()});
      if (ack === 1'b1 && we === 1'b0 && val_q.size() > 0)
         check(dat_r & msk_q.pop_front(), val_q.pop_front());
   end

   task automatic wb(input logic w, input logic [4:0] a,
                     input logic [31:0] d);
      @(posedge clk);
      cyc <= 1'b1;
      stb <= 1'b1;
      we <= w;
      adr <= a;
      dat_w <= d;
      do @(posedge clk); while (ack !== 1'b1);
      cyc <= 1'b0;
      stb <= 1'b0;
   endtask : wb

   task automatic rd(input logic [4:0] a, input logic [31:0] e,
                     input logic [31:0] m);
      val_q.push_back(e & m);
      msk_q.push_back(m);
      wb(1'b0, a, 32'h0);
   endtask : rd

   task automatic expect_tel(input logic v);
      tel_q.push_back(v);
      tel_total++;
   endtask : expect_tel

   task automatic set_ctrl(input int m, input int s, input logic so,
                           input int cy, input int on, input int off);
      cur_mode = m;
      soc_on = so;
      wb(1'b1, `TLM_OFS_CTRL, 32'(m) | (32'(s) << `TLM_CTRL_SRC_LSB)
         | (32'(so) << `TLM_CTRL_SOC_BIT) | (32'(cy) << `TLM_CTRL_CYC_LSB)
         | (32'(on) << `TLM_CTRL_ON_LSB) | (32'(off) << `TLM_CTRL_OFF_LSB));
   endtask : set_ctrl

   task automatic samp(input logic [15:0] v);
      @(posedge clk);
      sample <= v;
      sample_vld <= 1'b1;
      @(posedge clk);
      sample_vld <= 1'b0;
   endtask : samp

   // region 0 inside band, 1 high side, 2 low side
   task automatic step(input logic [15:0] v, input int reg_sel);
      logic [1:0] a;
      samp(v);
      a = (reg_sel == 1) ? act_tab[cur_mode][3:2]
         : (reg_sel == 2) ? act_tab[cur_mode][1:0] : 2'h0;
      if (a != 2'h0)
      begin
         if (lim_ok && soc_on && (a == 2'h1) != lim_exp)
            expect_tel(a == 2'h1);
         lim_exp = (a == 2'h1);
         lim_ok = 1'b1;
      end
      repeat (4) @(posedge clk);
      if (lim_ok)
         check({31'h0, limit}, {31'h0, lim_exp});
   endtask : step

   task automatic do_reset();
      rst <= 1'b1;
      repeat (6) @(posedge clk);
      rst <= 1'b0;
      lim_exp = 1'b0;
      lim_ok = 1'b1;
   endtask : do_reset

   initial
   begin
      do_reset();
      rd(`TLM_OFS_CTRL, 32'h0, 32'hFFFFFFFF);
      rd(`TLM_OFS_THR, 32'h0, 32'hFFFFFFFF);
      rd(`TLM_OFS_STATUS, 32'h0, 32'hFFFFFFFF);
      wb(1'b1, 5'h10, 32'hFFFFFFFF);
      rd(5'h10, 32'h0, 32'hFFFFFFFF);
      wb(1'b1, `TLM_OFS_THR, 32'h0000003C);
      rd(`TLM_OFS_STATUS, 32'h01F40000, 32'hFFFF0000);
      wb(1'b1, `TLM_OFS_THR, 32'h000000F1);
      rd(`TLM_OFS_STATUS, 32'hFF6A0000, 32'hFFFF0000);
      set_ctrl(0, 1, 1'b0, 0, 0, 0);
      r = 16'(($random(seed) % 150) + 200);
      far.send16(r);
      far.send8(8'h07);
      rd(`TLM_OFS_STATUS, {r, 16'h0010}, 32'hFFFF0010);
      wb(1'b1, `TLM_OFS_THR, 32'h00000014);
      rd(`TLM_OFS_STATUS, 32'h00C80000, 32'hFFFF0010);
      set_ctrl(0, 2, 1'b0, 0, 0, 0);
      far.send8(8'hF9);
      rd(`TLM_OFS_STATUS, 32'hFFBA0010, 32'hFFFF0010);
      set_ctrl(0, 3, 1'b0, 0, 0, 0);
      samp(16'h007B);
      far.teach();
      rd(`TLM_OFS_STATUS, 32'h007B0000, 32'hFFFF0000);
      rd(`TLM_OFS_SAMPLE, 32'h0000007B, 32'h0000FFFF);
      for (int m = 0; m < 12; m++)
      begin
         do_reset();
         wb(1'b1, `TLM_OFS_THR, 32'h00000100);
         set_ctrl(m, 0, 1'b0, 0, 0, 0);
         samp(LO);
         lim_ok = 1'b0;
         step(HI, 1);
         step(LO, 2);
         set_ctrl(m, 0, 1'b1, 0, 0, 0);
         step(HI, 1);
         step(LO, 2);
      end
      // widest hysteresis, sample inside the band holds the state
      do_reset();
      wb(1'b1, `TLM_OFS_THR, 32'h00000800);
      set_ctrl(0, 0, 1'b1, 0, 0, 0);
      step(16'h012C, 1);
      step(16'hFF6A, 0);
      step(16'hFF06, 2);
      // cyclic only, low side gives no telegram
      do_reset();
      set_ctrl(4, 0, 1'b0, 1, 0, 0);
      expect_tel(1'b1);
      repeat (8) @(posedge clk);
      step(HI, 1);
      repeat (36) @(posedge clk);
      step(LO, 2);
      repeat (74) @(posedge clk);
      set_ctrl(4, 0, 1'b0, 0, 0, 0);
      // delays against a 10 s cycle: 1 min on, 10 s off
      do_reset();
      set_ctrl(0, 0, 1'b1, 1, 7, 4);
      for (int i = 10; i >= 0; i--)
         expect_tel(pat[i]);
      repeat (18) @(posedge clk);
      samp(HI);
      repeat (230) @(posedge clk);
      check({31'h0, limit}, 32'h0);
      repeat (40) @(posedge clk);
      check({31'h0, limit}, 32'h1);
      samp(LO);
      repeat (33) @(posedge clk);
      check({31'h0, limit}, 32'h1);
      repeat (40) @(posedge clk);
      check({31'h0, limit}, 32'h0);
      set_ctrl(0, 0, 1'b1, 0, 4, 4);
      repeat (20) @(posedge clk);
      // clock enable low: a sample strobe must be ignored
      @(posedge clk);
      ce <= 1'b0;
      samp(HI);
      @(posedge clk);
      ce <= 1'b1;
      repeat (4) @(posedge clk);
      check({31'h0, limit}, 32'h0);
      check(32'(tel_q.size()), 32'h0);
      check({16'h0, tel_cnt}, 32'(tel_total));
      stop_test();
   end
endmodule : tlm_monitor_bench
`default_nettype wire
